/* File: src/cbitc_pkg.sv */
package cbitc_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_PS = 8000;
    localparam int RESP_MIN_NS = 140;
    localparam int RESP_MAX_NS = 280;
    localparam int EXT_SAMPLE_NS = 28;
    localparam int RESP_MIN_CYC = (RESP_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RESP_MAX_CYC = (RESP_MAX_NS * 1000) / CLK_PERIOD_PS;
    localparam int EXT_SAMPLE_CYC = (EXT_SAMPLE_NS * 1000) / CLK_PERIOD_PS;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] A_PSW = 8'h00;
    localparam logic [7:0] A_CP = 8'h01;
    localparam logic [7:0] A_TFR = 8'h02;
    localparam logic [7:0] A_STAT = 8'h03;
    localparam logic [7:0] A_SRC = 8'h10;
    localparam logic [7:0] A_PCTL = 8'h20;
    localparam logic [7:0] A_PSRC = 8'h28;
    localparam logic [7:0] A_PDST = 8'h30;

    // ****************************************
    // field positions
    // ****************************************
    localparam int C_REQ = 7;
    localparam int C_EN = 6;
    localparam int P_ILVL = 12;
    localparam int P_TRAP = 9;
    localparam int K_BYTE = 8;
    localparam int K_INCD = 9;
    localparam int K_INCS = 10;
    localparam int K_CONT = 11;
    localparam int OP_LONG_BIT = 0;
    localparam int T_MISALIGN = 0;
    localparam int T_STK_UNF = 1;
    localparam int T_STK_OVF = 2;
    localparam int T_HWERR = 3;

    // ****************************************
    // reset values and codes
    // ****************************************
    localparam logic [15:0] PSW_RST = 16'h0000;
    localparam logic [15:0] CP_RST = 16'h0000;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [11:0] PCTL_RST = 12'h000;
    localparam logic [15:0] PTR_RST = 16'h0000;
    localparam logic [3:0] PEC_LVL_MIN = 4'hE;
    localparam logic [7:0] VEC_TRAP_BASE = 8'h00;
    localparam logic [7:0] VEC_INT_BASE = 8'h10;

    typedef enum logic [2:0] {ST_IDLE, ST_SAVE_PSW, ST_SAVE_IP, ST_WAIT, ST_RET_IP, ST_RET_PSW} cbitc_state_t;
    typedef enum logic [1:0] {BOP_AND, BOP_OR, BOP_XOR, BOP_MOV} cbitc_bop_t;

endpackage

/* File: src/cbitc_core.sv */
module cbitc_core #(
    parameter int SRC_N = 16,
    parameter int EXT_N = 4,
    parameter int PEC_N = 8,
    parameter int STK_DEPTH = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // request sources
    input wire logic [SRC_N-1:0] src_req,
    input wire logic [EXT_N-1:0] ext_irq_pin,
    input wire logic hw_err,
    // cpu service
    input wire logic [15:0] cpu_ip,
    input wire logic md_busy,
    input wire logic reti_req,
    input wire logic ret_call,
    output logic int_take,
    output logic [7:0] int_vector,
    output logic int_is_trap,
    output logic md_abort,
    output logic ret_valid,
    output logic [15:0] ret_ip,
    // event transfer
    output logic pec_go,
    output logic [15:0] pec_src,
    output logic [15:0] pec_dst,
    output logic pec_byte,
    // branch unit
    input wire logic br_valid,
    input wire logic br_taken,
    input wire logic br_call,
    input wire logic [15:0] br_offset,
    output logic [15:0] br_target,
    output logic br_stall,
    // fetch
    input wire logic fetch_valid,
    input wire logic [15:0] fetch_addr,
    input wire logic [15:0] instr_word,
    output logic instr_two_words,
    // shifter
    input wire logic [15:0] sh_in,
    input wire logic [3:0] sh_cnt,
    input wire logic sh_left,
    input wire logic sh_arith,
    output logic [15:0] sh_out,
    // bit and bit-field
    input wire logic [15:0] bit_wa,
    input wire logic [3:0] bit_pa,
    input wire logic [15:0] bit_wb,
    input wire logic [3:0] bit_pb,
    input wire logic [1:0] bit_op,
    output logic bit_res,
    output logic [15:0] bit_word,
    input wire logic [15:0] bf_data,
    input wire logic [15:0] bf_mask,
    input wire logic [15:0] bf_val,
    output logic [15:0] bf_out,
    // register bank
    output logic [15:0] gpr_base
);

    localparam int SPW = $clog2(STK_DEPTH) + 1;

    if (SRC_N < 2 || SRC_N > 16 || EXT_N < 1 || EXT_N >= SRC_N || PEC_N != 8 || STK_DEPTH < 4 ||
        STK_DEPTH > 64 || (STK_DEPTH & (STK_DEPTH - 1)) != 0 || cbitc_pkg::RESP_MIN_CYC < 4 ||
        cbitc_pkg::RESP_MIN_CYC > cbitc_pkg::RESP_MAX_CYC || cbitc_pkg::EXT_SAMPLE_CYC < 1) begin : g_bad
        $error("cbitc_core: unsupported parameters");
    end

    // ****************************************
    // state
    // ****************************************
    cbitc_pkg::cbitc_state_t st_r, st_nxt;
    logic [15:0] psw_r, psw_nxt, cp_r, ip_r;
    logic [3:0] tfr_r, tpend_r;
    logic [7:0] ctrl_r [SRC_N];
    logic [7:0] ctrl_nxt [SRC_N];
    logic [11:0] pctl_r [PEC_N];
    logic [15:0] psrc_r [PEC_N];
    logic [15:0] pdst_r [PEC_N];
    logic [15:0] stk_mem [STK_DEPTH];
    logic [SPW-1:0] sp_r;
    logic [5:0] wcnt_r;
    logic [7:0] svc_vec_r;
    logic svc_trap_r;
    logic [3:0] svc_lvl_r;
    logic [2:0] svc_tlvl_r;
    logic [EXT_N-1:0] ext_s1_r, ext_s2_r, ext_s3_r;
    logic jc_valid_r;
    logic [15:0] jc_ip_r;

    // ****************************************
    // external pins: two-stage sync, edge capture
    // ****************************************
    // sampled every cycle, well inside the 28 ns sample interval
    wire [EXT_N-1:0] ext_edge = ext_s2_r & ~ext_s3_r;
    wire [SRC_N-1:0] ext_pad = {{(SRC_N - EXT_N){1'b0}}, ext_edge};

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ext_s1_r <= '0;
            ext_s2_r <= '0;
            ext_s3_r <= '0;
        end else begin
            ext_s1_r <= ext_irq_pin;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
        end
    end

    // ****************************************
    // arbitration
    // ****************************************
    logic best_hit;
    logic [5:0] best_key;
    logic [3:0] best_idx;
    logic trap_hit;
    logic [1:0] trap_idx;

    always_comb begin
        best_hit = 1'b0;
        best_key = 6'h00;
        best_idx = 4'h0;
        for (int i = 0; i < SRC_N; i++) begin
            if (ctrl_r[i][cbitc_pkg::C_EN] && ctrl_r[i][cbitc_pkg::C_REQ] &&
                (!best_hit || ctrl_r[i][5:0] > best_key)) begin
                best_hit = 1'b1;
                best_key = ctrl_r[i][5:0];
                best_idx = 4'(i);
            end
        end
    end

    always_comb begin
        trap_hit = 1'b0;
        trap_idx = 2'h0;
        for (int j = 0; j < 4; j++) begin
            if (tpend_r[j]) begin
                trap_hit = 1'b1;
                trap_idx = 2'(j);
            end
        end
    end

    wire idle = st_r == cbitc_pkg::ST_IDLE;
    wire ret_any = reti_req | ret_call;
    wire [3:0] best_lvl = best_key[5:2];
    wire [3:0] psw_ilvl = psw_r[cbitc_pkg::P_ILVL +: 4];
    wire [2:0] psw_tlvl = psw_r[cbitc_pkg::P_TRAP +: 3];
    wire [2:0] trap_lvl = {1'b0, trap_idx} + 3'd1;
    wire [2:0] pec_ch = {best_lvl[0], best_key[1:0]};
    wire is_pec = best_lvl >= cbitc_pkg::PEC_LVL_MIN;
    wire pec_live = pctl_r[pec_ch][7:0] != 8'h00 || pctl_r[pec_ch][cbitc_pkg::K_CONT];
    // a trap is refused while an equal or higher trap is in service, while the sequencer is not idle, or while a return is requested
    wire trap_go = idle && !ret_any && trap_hit && trap_lvl > psw_tlvl;
    // strict compare: equal level, any group, never preempts
    wire int_go = idle && !ret_any && !trap_go && best_hit && psw_tlvl == 3'd0 &&
        best_lvl > psw_ilvl;
    wire pec_now = int_go && is_pec && pec_live;
    wire cpu_go = int_go && !(is_pec && pec_live);
    wire ack_src = pec_now | cpu_go;
    wire take_now = st_r == cbitc_pkg::ST_WAIT && wcnt_r == 6'(cbitc_pkg::RESP_MIN_CYC - 1);

    // ****************************************
    // per-source control registers
    // ****************************************
    for (genvar i = 0; i < SRC_N; i++) begin : g_src
        wire [7:0] a_me = cbitc_pkg::A_SRC + 8'(i);
        wire [7:0] base = (reg_wr && reg_addr == a_me) ? reg_wdata[7:0] : ctrl_r[i];
        wire ack_me = ack_src && best_idx == 4'(i);
        // a new request in the acknowledge cycle survives
        wire req = (base[cbitc_pkg::C_REQ] && !ack_me) || src_req[i] || ext_pad[i];
        assign ctrl_nxt[i] = {req, base[cbitc_pkg::C_REQ-1:0]};

        always_ff @(posedge clk) begin
            if (!nrst) begin
                ctrl_r[i] <= cbitc_pkg::CTRL_RST;
            end else begin
                ctrl_r[i] <= ctrl_nxt[i];
            end
        end
    end

    // ****************************************
    // event transfer channels
    // ****************************************
    for (genvar c = 0; c < PEC_N; c++) begin : g_pec
        wire svc = pec_now && pec_ch == 3'(c);
        wire cont = pctl_r[c][cbitc_pkg::K_CONT];
        wire incs = pctl_r[c][cbitc_pkg::K_INCS];
        wire incd = pctl_r[c][cbitc_pkg::K_INCD] && !incs;
        wire [15:0] step = pctl_r[c][cbitc_pkg::K_BYTE] ? 16'h0001 : 16'h0002;
        wire wr_ctl = reg_wr && reg_addr == cbitc_pkg::A_PCTL + 8'(c);
        wire wr_src = reg_wr && reg_addr == cbitc_pkg::A_PSRC + 8'(c);
        wire wr_dst = reg_wr && reg_addr == cbitc_pkg::A_PDST + 8'(c);

        always_ff @(posedge clk) begin
            if (!nrst) begin
                pctl_r[c] <= cbitc_pkg::PCTL_RST;
                psrc_r[c] <= cbitc_pkg::PTR_RST;
                pdst_r[c] <= cbitc_pkg::PTR_RST;
            end else begin
                if (svc && !cont) begin
                    pctl_r[c] <= {pctl_r[c][11:8], pctl_r[c][7:0] - 8'h01};
                end else if (wr_ctl) begin
                    pctl_r[c] <= reg_wdata[11:0];
                end
                if (svc && incs) begin
                    psrc_r[c] <= psrc_r[c] + step;
                end else if (wr_src) begin
                    psrc_r[c] <= reg_wdata;
                end
                if (svc && incd) begin
                    pdst_r[c] <= pdst_r[c] + step;
                end else if (wr_dst) begin
                    pdst_r[c] <= reg_wdata;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pec_go <= 1'b0;
            pec_src <= 16'h0000;
            pec_dst <= 16'h0000;
            pec_byte <= 1'b0;
        end else begin
            pec_go <= pec_now;
            if (pec_now) begin
                pec_src <= psrc_r[pec_ch];
                pec_dst <= pdst_r[pec_ch];
                pec_byte <= pctl_r[pec_ch][cbitc_pkg::K_BYTE];
            end
        end
    end

    // ****************************************
    // system stack
    // ****************************************
    wire save_psw = st_r == cbitc_pkg::ST_SAVE_PSW;
    wire save_ip = st_r == cbitc_pkg::ST_SAVE_IP;
    wire call_push = idle && !ret_any && br_valid && br_call;
    wire call_pop = idle && ret_call && !reti_req;
    wire push_req = save_psw || save_ip || call_push;
    wire pop_req = st_r == cbitc_pkg::ST_RET_IP || st_r == cbitc_pkg::ST_RET_PSW || call_pop;
    wire [15:0] push_data = save_psw ? psw_r : (save_ip ? ip_r : cpu_ip);
    wire stk_full = sp_r == SPW'(STK_DEPTH);
    wire stk_empty = sp_r == '0;
    wire [SPW-1:0] sp_m1 = sp_r - 1'b1;
    wire [15:0] stk_top = stk_empty ? 16'h0000 : stk_mem[sp_m1[SPW-2:0]];

    always_ff @(posedge clk) begin
        if (push_req && !stk_full) begin
            stk_mem[sp_r[SPW-2:0]] <= push_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            sp_r <= '0;
        end else if (push_req && !stk_full) begin
            sp_r <= sp_r + 1'b1;
        end else if (pop_req && !stk_empty) begin
            sp_r <= sp_m1;
        end
    end

    // ****************************************
    // traps
    // ****************************************
    wire [3:0] tev;
    assign tev[cbitc_pkg::T_MISALIGN] = fetch_valid && fetch_addr[0];
    assign tev[cbitc_pkg::T_STK_UNF] = pop_req && stk_empty;
    assign tev[cbitc_pkg::T_STK_OVF] = push_req && stk_full;
    assign tev[cbitc_pkg::T_HWERR] = hw_err;
    wire wr_tfr = reg_wr && reg_addr == cbitc_pkg::A_TFR;
    wire [3:0] tfr_clr = wr_tfr ? reg_wdata[3:0] : 4'h0;
    wire [3:0] tpend_clr = trap_go ? (4'h1 << trap_idx) : 4'h0;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            tfr_r <= 4'h0;
            tpend_r <= 4'h0;
        end else begin
            tfr_r <= (tfr_r & ~tfr_clr) | tev;
            tpend_r <= (tpend_r & ~tpend_clr) | tev;
        end
    end

    // ****************************************
    // service sequencer
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            cbitc_pkg::ST_IDLE: begin
                if (reti_req) begin
                    st_nxt = cbitc_pkg::ST_RET_IP;
                end else if (trap_go || cpu_go) begin
                    st_nxt = cbitc_pkg::ST_SAVE_PSW;
                end
            end
            cbitc_pkg::ST_SAVE_PSW: st_nxt = cbitc_pkg::ST_SAVE_IP;
            cbitc_pkg::ST_SAVE_IP: st_nxt = cbitc_pkg::ST_WAIT;
            cbitc_pkg::ST_WAIT: begin
                if (take_now) begin
                    st_nxt = cbitc_pkg::ST_IDLE;
                end
            end
            cbitc_pkg::ST_RET_IP: st_nxt = cbitc_pkg::ST_RET_PSW;
            default: st_nxt = cbitc_pkg::ST_IDLE;
        endcase
    end

    wire wr_psw = reg_wr && reg_addr == cbitc_pkg::A_PSW;
    always_comb begin
        psw_nxt = psw_r;
        if (save_ip) begin
            psw_nxt[cbitc_pkg::P_ILVL +: 4] = svc_lvl_r;
            psw_nxt[cbitc_pkg::P_TRAP +: 3] = svc_tlvl_r;
        end else if (st_r == cbitc_pkg::ST_RET_PSW) begin
            psw_nxt = stk_top;
        end else if (wr_psw) begin
            psw_nxt = reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_r <= cbitc_pkg::ST_IDLE;
            psw_r <= cbitc_pkg::PSW_RST;
            wcnt_r <= 6'h00;
        end else begin
            st_r <= st_nxt;
            psw_r <= psw_nxt;
            wcnt_r <= idle ? 6'h00 : wcnt_r + 6'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ip_r <= 16'h0000;
            svc_vec_r <= 8'h00;
            svc_trap_r <= 1'b0;
            svc_lvl_r <= 4'h0;
            svc_tlvl_r <= 3'h0;
        end else if (trap_go) begin
            ip_r <= cpu_ip;
            svc_vec_r <= cbitc_pkg::VEC_TRAP_BASE + {6'h00, trap_idx};
            svc_trap_r <= 1'b1;
            svc_lvl_r <= psw_ilvl;
            svc_tlvl_r <= trap_lvl;
        end else if (cpu_go) begin
            ip_r <= cpu_ip;
            svc_vec_r <= cbitc_pkg::VEC_INT_BASE + {4'h0, best_idx};
            svc_trap_r <= 1'b0;
            svc_lvl_r <= best_lvl;
            svc_tlvl_r <= psw_tlvl;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            int_take <= 1'b0;
            int_vector <= 8'h00;
            int_is_trap <= 1'b0;
            md_abort <= 1'b0;
            ret_valid <= 1'b0;
            ret_ip <= 16'h0000;
        end else begin
            int_take <= take_now;
            md_abort <= take_now && md_busy;
            ret_valid <= st_r == cbitc_pkg::ST_RET_PSW || call_pop;
            if (take_now) begin
                int_vector <= svc_vec_r;
                int_is_trap <= svc_trap_r;
            end
            if (st_r == cbitc_pkg::ST_RET_IP || call_pop) begin
                ret_ip <= stk_top;
            end
        end
    end

    // ****************************************
    // branch timing and loop cache
    // ****************************************
    wire br_go = br_valid && (br_taken || br_call);
    wire jc_hit = jc_valid_r && jc_ip_r == cpu_ip;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            jc_valid_r <= 1'b0;
            jc_ip_r <= 16'h0000;
            br_target <= 16'h0000;
            br_stall <= 1'b0;
        end else begin
            if (br_valid) begin
                br_target <= cpu_ip + br_offset;
            end
            br_stall <= br_go && !jc_hit;
            if (br_go) begin
                jc_valid_r <= 1'b1;
                jc_ip_r <= cpu_ip;
            end
        end
    end

    // ****************************************
    // datapath helpers
    // ****************************************
    wire bit_a = bit_wa[bit_pa];
    wire bit_b = bit_wb[bit_pb];
    wire bres = bit_op == cbitc_pkg::BOP_AND ? (bit_a & bit_b) :
        bit_op == cbitc_pkg::BOP_OR ? (bit_a | bit_b) :
        bit_op == cbitc_pkg::BOP_XOR ? (bit_a ^ bit_b) : bit_b;
    wire [15:0] bmask = 16'h0001 << bit_pa;
    wire [15:0] sh_ar = $signed(sh_in) >>> sh_cnt;
    wire [15:0] sh_nxt = sh_left ? (sh_in << sh_cnt) : (sh_arith ? sh_ar : (sh_in >> sh_cnt));

    always_ff @(posedge clk) begin
        if (!nrst) begin
            sh_out <= 16'h0000;
            bit_res <= 1'b0;
            bit_word <= 16'h0000;
            bf_out <= 16'h0000;
            instr_two_words <= 1'b0;
        end else begin
            sh_out <= sh_nxt;
            bit_res <= bres;
            bit_word <= (bit_wa & ~bmask) | (bres ? bmask : 16'h0000);
            bf_out <= (bf_data & ~bf_mask) | (bf_val & bf_mask);
            instr_two_words <= instr_word[cbitc_pkg::OP_LONG_BIT];
        end
    end

    // ****************************************
    // register bank and register port
    // ****************************************
    wire wr_cp = reg_wr && reg_addr == cbitc_pkg::A_CP;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cp_r <= cbitc_pkg::CP_RST;
        end else if (wr_cp) begin
            cp_r <= {reg_wdata[15:1], 1'b0};
        end
    end
    assign gpr_base = cp_r;

    wire src_hit = reg_addr[7:4] == cbitc_pkg::A_SRC[7:4] && {1'b0, reg_addr[3:0]} < 5'(SRC_N);
    wire pctl_hit = reg_addr[7:3] == cbitc_pkg::A_PCTL[7:3];
    wire psrc_hit = reg_addr[7:3] == cbitc_pkg::A_PSRC[7:3];
    wire pdst_hit = reg_addr[7:3] == cbitc_pkg::A_PDST[7:3];
    wire [15:0] stat = {8'(sp_r), 5'h00, st_r};
    wire [15:0] rd_val = reg_addr == cbitc_pkg::A_PSW ? psw_r :
        reg_addr == cbitc_pkg::A_CP ? cp_r :
        reg_addr == cbitc_pkg::A_TFR ? {12'h000, tfr_r} :
        reg_addr == cbitc_pkg::A_STAT ? stat :
        src_hit ? {8'h00, ctrl_r[reg_addr[3:0]]} :
        pctl_hit ? {4'h0, pctl_r[reg_addr[2:0]]} :
        psrc_hit ? psrc_r[reg_addr[2:0]] :
        pdst_hit ? pdst_r[reg_addr[2:0]] : 16'h0000;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= reg_rd ? rd_val : 16'h0000;
        end
    end

endmodule

/* File: sim/cbitc_checker.sv */
module cbitc_checker (
    // watched ports
    input wire logic clk, nrst, reg_rd, int_take, md_abort, md_busy, sh_left, br_valid, br_taken,
    input wire logic br_call, br_stall, ret_valid,
    input wire logic [3:0] sh_cnt,
    input wire logic [15:0] reg_rdata, cpu_ip, br_offset, br_target, sh_in, sh_out, bf_data, bf_mask,
    input wire logic [15:0] bf_val, bf_out,
    input wire logic bit_res,
    input wire logic [1:0] bit_op,
    input wire logic [3:0] bit_pa, bit_pb,
    input wire logic [15:0] bit_wa, bit_wb
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] up_r;
    always_ff @(posedge clk) up_r <= nrst ? {up_r[0], 1'b1} : 2'b00;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // ****
    // port rules
    // ****
    a_rdata_quiet: assert property (up_r[1] && !$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data out of slot");
    a_take_single: assert property (int_take |=> !int_take [*8])
        else $error("branch pulse too long");
    a_abort_cause: assert property (md_abort |-> int_take && $past(md_busy))
        else $error("abort without busy");
    a_target_calc: assert property (br_valid |=> br_target == $past(cpu_ip) + $past(br_offset))
        else $error("bad branch target");
    a_stall_cause:
        assert property (br_stall |-> $past(br_valid) && ($past(br_taken) || $past(br_call)))
        else $error("stall without taken branch");
    a_untaken_free: assert property (br_valid && !br_taken && !br_call |=> !br_stall)
        else $error("stall on untaken branch");
    a_shift_single: assert property (up_r[1] && sh_left |=> sh_out == ($past(sh_in) << $past(sh_cnt)))
        else $error("bad shift");
    a_field_merge:
        assert property (up_r[1] |=> bf_out == (($past(bf_data) & ~$past(bf_mask)) | ($past(bf_val) & $past(bf_mask))))
        else $error("bad field merge");
    a_bit_combine:
        assert property (up_r[1] && bit_op == 2'h0 |=> bit_res == ($past(bit_wa[bit_pa]) & $past(bit_wb[bit_pb])))
        else $error("bad bit combine");
    c_take: cover property (int_take);
    c_stall: cover property (br_stall);
    c_ret: cover property (ret_valid);
endmodule

bind cbitc_core cbitc_checker u_cbitc_checker (.clk, .nrst, .reg_rd, .int_take, .md_abort, .md_busy, .sh_left,
    .br_valid, .br_taken, .br_call, .br_stall, .ret_valid, .sh_cnt, .reg_rdata, .cpu_ip, .br_offset,
    .br_target, .sh_in, .sh_out, .bf_data, .bf_mask, .bf_val, .bf_out, .bit_res, .bit_op, .bit_pa, .bit_pb,
    .bit_wa, .bit_wb);

/* File: sim/cbitc_periph.sv */
module cbitc_periph (
    // clock
    input wire logic clk,
    // request lines
    output logic [15:0] src_req = 16'h0000,
    output logic [3:0] ext_irq_pin = 4'h0,
    output logic hw_err = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    // one-cycle pulse of a source, or of the error line when i is negative
    task automatic fire(input int i);
        @(posedge clk);
        if (i < 0) hw_err <= 1'b1;
        else src_req[i] <= 1'b1;
        @(posedge clk);
        hw_err <= 1'b0;
        src_req <= 16'h0000;
    endtask
    // pin pulse one clock long
    task automatic pin(input int i);
        @(posedge clk) ext_irq_pin[i] <= 1'b1;
        @(posedge clk) ext_irq_pin <= 4'h0;
    endtask
endmodule

/* File: sim/cbitc_core_test.sv */
module cbitc_core_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, reti_req = 1'b0, br_valid = 1'b0, br_taken = 1'b0;
    logic [7:0] reg_addr = 8'h00, int_vector;
    logic [15:0] reg_wdata = 16'h0000, cpu_ip = 16'h0000, br_offset = 16'h0000, lf = 16'hACE1;
    logic [15:0] reg_rdata, ret_ip, br_target, src_req, pec_src, gb;
    logic br_call = 1'b0, ret_call = 1'b0, fv = 1'b0, pec_go;
    logic [3:0] ext_irq_pin;
    logic hw_err, int_take, int_is_trap, ret_valid, br_stall;
    int mismatches = 0;
    int comparisons = 0;
    always #4 clk = ~clk;
    // ****
    // stimulus for the datapath helpers
    // ****
    always @(posedge clk) lf <= {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    cbitc_periph u_cbitc_periph (.clk, .src_req, .ext_irq_pin, .hw_err);
    cbitc_core u_cbitc_core (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .src_req,
        .ext_irq_pin, .hw_err, .cpu_ip, .md_busy(lf[5]), .reti_req, .ret_call, .int_take, .int_vector,
        .int_is_trap, .md_abort(), .ret_valid, .ret_ip, .pec_go, .pec_src, .pec_dst(), .pec_byte(),
        .br_valid, .br_taken, .br_call, .br_offset, .br_target, .br_stall, .fetch_valid(fv),
        .fetch_addr(cpu_ip), .instr_word(lf), .instr_two_words(), .sh_in(lf), .sh_cnt(lf[7:4]),
        .sh_left(lf[0]), .sh_arith(lf[1]), .sh_out(), .bit_wa(lf), .bit_pa(lf[3:0]), .bit_wb(~lf),
        .bit_pb(lf[11:8]), .bit_op(lf[9:8]), .bit_res(), .bit_word(), .bf_data(lf),
        .bf_mask({lf[7:0], lf[15:8]}), .bf_val(~lf), .bf_out(), .gpr_base(gb));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; end
        @(posedge clk) reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk) begin reg_rd <= 1'b1; reg_addr <= a; end
        @(posedge clk) reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    // cycles until the core branches, 0 if quiet for 40
    task automatic wt(output int n);
        n = 0;
        do @(posedge clk) #1 n++; while (int_take !== 1'b1 && n < 40);
        if (int_take !== 1'b1) n = 0;
    endtask
    task automatic take(input logic [7:0] v, input logic t);
        int n;
        wt(n);
        chk(16'(n >= 18 && n <= 35), 16'h0001);
        chk({int_is_trap, 7'h00, int_vector}, {t, 7'h00, v});
    endtask
    task automatic quiet();
        int n;
        wt(n);
        chk(16'(n), 16'h0000);
    endtask
    task automatic reti(input logic [15:0] ip);
        int n;
        @(posedge clk) reti_req <= 1'b1;
        @(posedge clk) reti_req <= 1'b0;
        for (n = 0; ret_valid !== 1'b1 && n < 8; n++) @(posedge clk) #1;
        chk(ret_ip, ip);
    endtask
    task automatic br(input logic tk, input logic s);
        @(posedge clk) begin br_valid <= 1'b1; br_taken <= tk; end
        @(posedge clk) br_valid <= 1'b0;
        #1 chk(br_target, 16'h00F0);
        chk({15'h0000, br_stall}, {15'h0000, s});
    endtask
    task automatic end_sim();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge clk);
        mismatches++;
        end_sim();
    end
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        wr(8'h12, 16'h0054);
        wr(8'h13, 16'h0054);
        wr(8'h11, 16'h005C);
        rd(8'h12, 16'h0054);
        rd(8'h7F, 16'h0000);
        @(posedge clk) cpu_ip <= 16'h0200;
        u_cbitc_periph.fire(2);
        take(8'h12, 1'b0);
        rd(8'h00, 16'h5000);
        rd(8'h12, 16'h0054);
        u_cbitc_periph.fire(3);
        quiet();
        @(posedge clk) cpu_ip <= 16'h0300;
        u_cbitc_periph.pin(1);
        take(8'h11, 1'b0);
        reti(16'h0300);
        quiet();
        reti(16'h0200);
        take(8'h13, 1'b0);
        reti(16'h0300);
        $display("test interrupts done");
        u_cbitc_periph.fire(-1);
        take(8'h03, 1'b1);
        rd(8'h02, 16'h0008);
        rd(8'h00, 16'h0800);
        u_cbitc_periph.fire(2);
        quiet();
        wr(8'h02, 16'h0008);
        rd(8'h02, 16'h0000);
        reti(16'h0300);
        take(8'h12, 1'b0);
        reti(16'h0300);
        $display("test traps done");
        @(posedge clk) begin cpu_ip <= 16'h0100; br_offset <= 16'hFFF0; end
        br(1'b1, 1'b1);
        br(1'b1, 1'b0);
        br(1'b0, 1'b0);
        @(posedge clk) br_call <= 1'b1;
        br(1'b0, 1'b0);
        @(posedge clk) begin br_call <= 1'b0; ret_call <= 1'b1; end
        @(posedge clk) ret_call <= 1'b0;
        #1 chk(ret_ip, 16'h0100);
        $display("test branches done");
        wr(8'h20, 16'h0401);
        wr(8'h28, 16'h1000);
        wr(8'h14, 16'h0078);
        u_cbitc_periph.fire(4);
        @(posedge clk) #1 chk(pec_src, 16'h1000);
        chk({15'h0000, pec_go}, 16'h0001);
        rd(8'h28, 16'h1002);
        rd(8'h20, 16'h0400);
        u_cbitc_periph.fire(4);
        take(8'h14, 1'b0);
        reti(16'h0100);
        @(posedge clk) begin fv <= 1'b1; cpu_ip <= 16'h0101; end
        @(posedge clk) fv <= 1'b0;
        take(8'h00, 1'b1);
        rd(8'h02, 16'h0001);
        reti(16'h0101);
        wr(8'h01, 16'h1235);
        #1 chk(gb, 16'h1234);
        $display("test events done");
        end_sim();
    end
endmodule
